// ---- logic/cwld_decoder.sv ----
// Compact word-load decoder with address generation, alignment policy and abort
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Immediate form: base plus imm5 times four
// - Register form: base plus offset, 32-bit read
// - Destination gets the loaded word unmodified
// - Unaligned off: data only when aligned
// - Alignment check on: misaligned aborts, alignment class
// - Check off, unaligned on: misaligned load works
// - Both off: misaligned result undefined
// - Legacy mode: optional abort on misalignment
// - Legacy word-invariant big endian is optional
// - PC form: PC low bits cleared plus imm8*4
// - SP form: stack pointer plus imm8 times four
// - Wide form write-back set iff base absent
// - PC form for literals, dest from 3-bit field
// - Base in list keeps loaded value
module cwld_decoder import cwld_pkg::*; #(
	parameter int unsigned XLEN = cwld_xlen
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Async reset, active low
	input wire logic issue_valid, // Instruction offered
	output logic issue_ready, // Decoder idle
	input wire logic [15:0] issue_instr, // 16-bit instruction
	output logic [2:0] rf_raddr_a, // Base register index
	output logic [2:0] rf_raddr_b, // Offset register index
	input wire logic [31:0] rf_rdata_a, // Base register value
	input wire logic [31:0] rf_rdata_b, // Offset register value
	input wire logic [31:0] pc_value, // Program counter as seen
	input wire logic [31:0] sp_value, // Stack pointer
	output logic mem_req, // Data read request
	output logic [31:0] mem_addr, // Data read address
	input wire logic mem_ack, // Read completed
	input wire logic [31:0] mem_rdata, // Read data
	input wire logic mem_err, // Bus error on read
	output logic rf_we, // Destination write strobe
	output logic [2:0] rf_waddr, // Destination index
	output logic [31:0] rf_wdata, // Destination value
	output logic abort_valid, // Data abort pulse
	output logic [1:0] abort_class, // Fault class
	output logic [31:0] abort_addr, // Fault address
	output logic [31:0] wide_instr, // Wide-form load-multiple
	output logic wide_valid, // Wide-form output valid
	output logic irq, // Interrupt level
	input wire logic [3:0] avs_address, // Avalon address
	input wire logic avs_read, // Avalon read
	input wire logic avs_write, // Avalon write
	input wire logic [31:0] avs_writedata, // Avalon write data
	input wire logic [3:0] avs_byteenable, // Avalon byte enables
	output logic [31:0] avs_readdata, // Avalon read data
	output logic avs_waitrequest // Avalon wait
);
	// Only a 32-bit data path is served
	if (XLEN != 32) begin : g_xlen_check
		$error("cwld_decoder serves only 32-bit data");
	end

	typedef enum {cwld_idle, cwld_wait, cwld_done} cwld_state_t;

	function automatic cwld_dec_t cwld_decode(input logic [15:0] ins);
		cwld_dec_t d;
		d = '0;
		d.form = cwld_form_none;
		d.dest = ins[2:0];
		d.base = ins[5:3];
		d.offs = ins[8:6];
		d.imm5 = ins[10:6];
		d.imm8 = ins[7:0];
		if (ins[15:11] == cwld_op_imm) begin
			d.form = cwld_form_imm;
		end else if (ins[15:9] == cwld_op_reg7) begin
			d.form = cwld_form_reg;
		end else if (ins[15:11] == cwld_op_pcrel) begin
			d.form = cwld_form_pcrel;
			d.dest = ins[10:8];
		end else if (ins[15:11] == cwld_op_sprel) begin
			d.form = cwld_form_sprel;
			d.dest = ins[10:8];
		end else if (ins[15:11] == cwld_op_ldm) begin
			d.form = cwld_form_ldm;
			d.base = ins[10:8];
		end
		return d;
	endfunction : cwld_decode

	// True for the four single-word forms; load-multiple is only translated
	function automatic logic cwld_is_word_load(input cwld_form_t f);
		return (f == cwld_form_imm) || (f == cwld_form_reg)
			|| (f == cwld_form_pcrel) || (f == cwld_form_sprel);
	endfunction : cwld_is_word_load

	cwld_dec_t dec;
	cwld_state_t state;
	logic [31:0] next_addr;
	logic [2:0] ctrl;
	logic [cwld_ev_w-1:0] status;
	logic [cwld_ev_w-1:0] mask;
	logic [1:0] fault_class_q;
	logic [2:0] dest_q;
	logic misaligned;
	logic do_abort;
	logic ev_abort;
	logic ev_done;
	logic bus_rd_status;
	logic bus_wr;
	logic take_load;
	logic take_ldm;
	logic ev_bus;

	// ==========================================================
	// Decode and issue
	assign dec = cwld_decode(issue_instr);
	assign rf_raddr_a = dec.base;
	assign rf_raddr_b = dec.offs;
	// One load outstanding: a new form is taken only in idle
	assign issue_ready = (state == cwld_idle);
	assign take_load = issue_valid && issue_ready && cwld_is_word_load(dec.form);
	assign take_ldm = issue_valid && issue_ready && (dec.form == cwld_form_ldm);

	// ==========================================================
	// Address generation
	always_comb begin
		unique case (dec.form)
			cwld_form_imm: next_addr = rf_rdata_a + {25'h0, dec.imm5, 2'h0};
			cwld_form_reg: next_addr = rf_rdata_a + rf_rdata_b;
			cwld_form_pcrel: next_addr = (pc_value & cwld_pc_mask) + {22'h0, dec.imm8, 2'h0};
			cwld_form_sprel: next_addr = sp_value + {22'h0, dec.imm8, 2'h0};
			cwld_form_ldm: next_addr = rf_rdata_a;
			cwld_form_none: next_addr = rf_rdata_a;
			default: next_addr = rf_rdata_a;
		endcase
	end

	// Legacy optional abort honoured too; PC form is aligned by construction
	assign misaligned = (next_addr[1:0] != 2'h0);
	assign do_abort = misaligned && (ctrl[cwld_ctrl_acheck] || ctrl[cwld_ctrl_abort_opt]);

	// ==========================================================
	// Load sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= cwld_idle;
		end else begin
			unique case (state)
				cwld_idle: begin
					if (take_load) begin
						state <= do_abort ? cwld_done : cwld_wait;
					end
				end
				cwld_wait: begin
					if (mem_ack) begin
						state <= cwld_done;
					end
				end
				cwld_done: begin
					state <= cwld_idle;
				end
			endcase
		end
	end

	// Read request, held until the memory answers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_req <= 1'b0;
		end else if (take_load && !do_abort) begin
			mem_req <= 1'b1;
		end else if (mem_req && mem_ack) begin
			mem_req <= 1'b0;
		end
	end

	// Word-aligned bus address when unaligned support is off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr <= 32'h0;
			dest_q <= 3'h0;
		end else if (take_load) begin
			dest_q <= dec.dest;
			mem_addr <= ctrl[cwld_ctrl_unal] ? next_addr : {next_addr[31:2], 2'h0};
		end
	end

	assign ev_abort = take_load && do_abort;
	assign ev_done = (state == cwld_wait) && mem_ack && !mem_err;
	assign ev_bus = (state == cwld_wait) && mem_ack && mem_err;

	// ==========================================================
	// Write-back
	// Little-endian data only: the legacy word-invariant big-endian option is not offered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rf_we <= 1'b0;
			rf_waddr <= 3'h0;
			rf_wdata <= 32'h0;
		end else begin
			rf_we <= ev_done;
			if (ev_done) begin
				rf_waddr <= dest_q;
				rf_wdata <= mem_rdata;
			end
		end
	end

	// ==========================================================
	// Abort report
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_valid <= 1'b0;
			abort_class <= cwld_fault_none;
			abort_addr <= 32'h0;
		end else begin
			abort_valid <= ev_abort || ev_bus;
			if (ev_abort) begin
				abort_class <= cwld_fault_align;
				abort_addr <= next_addr;
			end else if (ev_bus) begin
				abort_class <= cwld_fault_bus;
				abort_addr <= mem_addr;
			end
		end
	end

	// Last fault class, kept for software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_class_q <= cwld_fault_none;
		end else if (ev_abort) begin
			fault_class_q <= cwld_fault_align;
		end else if (ev_bus) begin
			fault_class_q <= cwld_fault_bus;
		end
	end

	// ==========================================================
	// Wide-form translation of the load-multiple
	// Base in list: no write-back so the loaded value survives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wide_instr <= 32'h0;
			wide_valid <= 1'b0;
		end else begin
			wide_valid <= take_ldm;
			if (take_ldm) begin
				wide_instr <= cwld_wide_ldm_base
					| ({31'h0, ~issue_instr[dec.base]} << cwld_wide_wb_bit)
					| ({29'h0, dec.base} << cwld_wide_rn_pos)
					| {24'h0, dec.imm8};
			end
		end
	end

	// ==========================================================
	// Avalon-MM slave: zero wait, one-cycle waitrequest free
	assign avs_waitrequest = 1'b0;
	assign bus_wr = avs_write && avs_byteenable[0];
	assign bus_rd_status = avs_read && avs_address == cwld_reg_status;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= cwld_ctrl_reset;
		end else if (bus_wr && avs_address == cwld_reg_ctrl) begin
			ctrl <= avs_writedata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask <= '0;
		end else if (bus_wr && avs_address == cwld_reg_mask) begin
			mask <= avs_writedata[cwld_ev_w-1:0];
		end
	end

	// Set wins over read-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
		end else begin
			status <= (bus_rd_status ? '0 : status) | {ev_done, ev_abort || ev_bus};
		end
	end

	assign irq = |(status & mask);

	always_comb begin
		unique case (avs_address)
			cwld_reg_ctrl: avs_readdata = {29'h0, ctrl};
			cwld_reg_status: avs_readdata = {30'h0, status};
			cwld_reg_mask: avs_readdata = {30'h0, mask};
			cwld_reg_fault: avs_readdata = {30'h0, fault_class_q};
			default: avs_readdata = 32'h0;
		endcase
	end
endmodule : cwld_decoder

`default_nettype wire

// ---- logic/cwld_pkg.sv ----
// Shared constants, types and register map of the compact word-load decoder
`default_nettype none
package cwld_pkg;
	localparam int unsigned cwld_xlen = 32;
	// Upper five opcode bits of the 16-bit instruction; upper seven for the register form
	localparam logic [4:0] cwld_op_imm = 5'h0d;
	localparam logic [4:0] cwld_op_pcrel = 5'h09;
	localparam logic [4:0] cwld_op_sprel = 5'h13;
	localparam logic [4:0] cwld_op_ldm = 5'h19;
	localparam logic [6:0] cwld_op_reg7 = 7'h2c;
	// Wide-form load-multiple template, write-back bit position
	localparam logic [31:0] cwld_wide_ldm_base = 32'he8900000;
	localparam int unsigned cwld_wide_wb_bit = 21;
	localparam int unsigned cwld_wide_rn_pos = 16;
	localparam logic [31:0] cwld_pc_mask = 32'hfffffffc;
	localparam int unsigned cwld_word_shift = 2;
	// Register map (byte addresses)
	localparam logic [3:0] cwld_reg_ctrl = 4'h0;
	localparam logic [3:0] cwld_reg_status = 4'h4;
	localparam logic [3:0] cwld_reg_mask = 4'h8;
	localparam logic [3:0] cwld_reg_fault = 4'hc;
	localparam int unsigned cwld_ctrl_acheck = 0;
	localparam int unsigned cwld_ctrl_unal = 1;
	localparam int unsigned cwld_ctrl_abort_opt = 2;
	localparam logic [2:0] cwld_ctrl_reset = 3'h0;
	localparam int unsigned cwld_ev_abort = 0;
	localparam int unsigned cwld_ev_done = 1;
	localparam int unsigned cwld_ev_w = 2;
	// Fault class codes
	localparam logic [1:0] cwld_fault_none = 2'h0;
	localparam logic [1:0] cwld_fault_align = 2'h1;
	localparam logic [1:0] cwld_fault_bus = 2'h2;

	typedef enum logic [2:0] {
		cwld_form_none,
		cwld_form_imm,
		cwld_form_reg,
		cwld_form_pcrel,
		cwld_form_sprel,
		cwld_form_ldm
	} cwld_form_t;

	typedef struct packed {
		cwld_form_t form;
		logic [2:0] dest;
		logic [2:0] base;
		logic [2:0] offs;
		logic [7:0] imm8;
		logic [4:0] imm5;
	} cwld_dec_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic abort;
	} cwld_mem_t;
endpackage : cwld_pkg
`default_nettype wire

// ---- verif/cwld_decoder_properties.sv ----
// Concurrent checks on the compact word-load decoder ports
`timescale 1ns/1ps
`default_nettype none
module cwld_decoder_properties import cwld_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic issue_valid, // offer
	input wire logic issue_ready, // idle
	input wire logic [15:0] issue_instr, // instruction
	input wire logic [31:0] pc_value, // pc
	input wire logic mem_req, // read request
	input wire logic [31:0] mem_addr, // read address
	input wire logic mem_ack, // read done
	input wire logic [31:0] mem_rdata, // read data
	input wire logic mem_err, // bus error
	input wire logic rf_we, // write strobe
	input wire logic [31:0] rf_wdata, // write value
	input wire logic abort_valid, // abort pulse
	input wire logic [31:0] wide_instr, // wide form
	input wire logic wide_valid // wide valid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_pc_take;
		issue_valid && issue_ready && issue_instr[15:11] == cwld_op_pcrel;
	endsequence
	sequence s_read_end;
		mem_req && mem_ack;
	endsequence
	pc_addr_a: assert property (s_pc_take |=> mem_req &&
		mem_addr == ($past(pc_value) & cwld_pc_mask) + {$past(issue_instr[7:0]), 2'h0})
		else $error("pc load address wrong");
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("read request dropped");
	ack_release_a: assert property (s_read_end |=> !mem_req)
		else $error("read request not released");
	wdata_pass_a: assert property (s_read_end ##0 !mem_err |=> rf_we &&
		rf_wdata == $past(mem_rdata))
		else $error("loaded word not written");
	err_nowrite_a: assert property (s_read_end ##0 mem_err |=> !rf_we ##[0:2] abort_valid)
		else $error("bus error not aborted");
	abort_excl_a: assert property (abort_valid |-> !rf_we)
		else $error("write during abort");
	we_pulse_a: assert property (rf_we |=> !rf_we)
		else $error("write strobe too long");
	wide_wb_a: assert property (wide_valid |->
		wide_instr[cwld_wide_wb_bit] != wide_instr[wide_instr[18:16]])
		else $error("write-back bit wrong");
endmodule : cwld_decoder_properties
bind cwld_decoder cwld_decoder_properties u_props (
	.clk(clk),
	.rst_n(rst_n),
	.issue_valid(issue_valid),
	.issue_ready(issue_ready),
	.issue_instr(issue_instr),
	.pc_value(pc_value),
	.mem_req(mem_req),
	.mem_addr(mem_addr),
	.mem_ack(mem_ack),
	.mem_rdata(mem_rdata),
	.mem_err(mem_err),
	.rf_we(rf_we),
	.rf_wdata(rf_wdata),
	.abort_valid(abort_valid),
	.wide_instr(wide_instr),
	.wide_valid(wide_valid)
);
`default_nettype wire

// ---- verif/cwld_mem_model.sv ----
// Data memory partner model answering word reads
`timescale 1ns/1ps
`default_nettype none
module cwld_mem_model (
	input wire logic clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic mem_req, // read request
	input wire logic [31:0] mem_addr, // read address
	input wire logic [1:0] wait_cyc, // stall cycles
	input wire logic fail, // answer with error
	output logic mem_ack, // read done
	output logic [31:0] mem_rdata, // read data
	output logic mem_err // bus error
);
	logic [1:0] cnt;
	// Data toggles outside the ack cycle so a stale sample never matches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 2'h0;
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 32'h0;
		end else if (mem_req && !mem_ack && cnt == wait_cyc) begin
			cnt <= 2'h0;
			mem_ack <= 1'b1;
			mem_err <= fail;
			mem_rdata <= mem_addr ^ 32'h5a5a5a5a;
		end else begin
			cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : cwld_mem_model
`default_nettype wire

// ---- verif/tb_compact_word_load_decode.sv ----
// Self-checking bench for the compact word-load decoder
`timescale 1ns/1ps
`default_nettype none
module tb_compact_word_load_decode import cwld_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic fail = 1'b0, issue_ready, mem_req, mem_ack, mem_err, rf_we, abort_valid, wide_valid;
	logic irq, avs_waitrequest;
	logic [1:0] wait_cyc = 2'h0, abort_class;
	logic [2:0] rf_raddr_a, rf_raddr_b, rf_waddr;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [15:0] issue_instr = 16'h0;
	logic [31:0] rf_rdata_a = 32'h0, rf_rdata_b = 32'h0, pc_value = 32'h0, sp_value = 32'h0;
	logic [31:0] avs_writedata = 32'h0, mem_addr, mem_rdata, rf_wdata, abort_addr, wide_instr;
	logic [31:0] avs_readdata, q;
	int n_mismatch = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	cwld_decoder DUT (.*);
	cwld_mem_model u_mem (.*);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic ld(input logic [15:0] ins, input logic [31:0] ad, input logic [1:0] ab,
		input logic [2:0] rd);
		logic [31:0] ga;
		ga = 32'h0;
		@(posedge clk);
		issue_instr <= ins;
		issue_valid <= 1'b1;
		do @(posedge clk); while (issue_ready !== 1'b1);
		issue_valid <= 1'b0;
		for (int i = 0; i < 20 && !(rf_we | abort_valid | wide_valid); i++) begin
			@(posedge clk);
			if (mem_req === 1'b1) ga = mem_addr;
		end
		if (ins[15:11] == cwld_op_ldm) chk("wide", ad, wide_instr);
		else if (ab != 2'h0) begin
			chk("class", {30'h0, ab}, {30'h0, abort_class});
			chk("abort addr", ad, abort_addr);
		end else begin
			chk("addr", ad, ga);
			chk("data", ad ^ 32'h5a5a5a5a, rf_wdata);
			chk("dest", {29'h0, rd}, {29'h0, rf_waddr});
		end
		chk("flags", {29'h0, ab != 2'h0, ab == 2'h0 && ins[15:11] != cwld_op_ldm,
			ins[15:11] == cwld_op_ldm}, {29'h0, abort_valid, rf_we, wide_valid});
		if (ins[15:11] == cwld_op_imm || ins[15:9] == cwld_op_reg7)
			chk("base idx", {29'h0, ins[5:3]}, {29'h0, rf_raddr_a});
		if (ins[15:9] == cwld_op_reg7)
			chk("offset idx", {29'h0, ins[8:6]}, {29'h0, rf_raddr_b});
	endtask : ld
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, cwld_reg_ctrl, 32'h0);
		chk("ctrl", {29'h0, cwld_ctrl_reset}, q);
		bus(0, cwld_reg_mask, 32'h0);
		chk("mask", 32'h0, q);
		rf_rdata_a <= 32'h100;
		wait_cyc <= 2'h2;
		ld({cwld_op_imm, 5'h05, 3'h1, 3'h2}, 32'h114, 2'h0, 3'h2);
		rf_rdata_a <= 32'h200;
		rf_rdata_b <= 32'h24;
		ld({cwld_op_reg7, 3'h3, 3'h1, 3'h4}, 32'h224, 2'h0, 3'h4);
		pc_value <= 32'h1006;
		ld({cwld_op_pcrel, 3'h5, 8'h03}, 32'h1010, 2'h0, 3'h5);
		sp_value <= 32'h2000;
		wait_cyc <= 2'h0;
		ld({cwld_op_sprel, 3'h6, 8'hff}, 32'h23fc, 2'h0, 3'h6);
		bus(0, cwld_reg_status, 32'h0);
		chk("status", 32'h2, q);
		$display("Aligned load forms done");
		rf_rdata_a <= 32'h101;
		ld({cwld_op_imm, 5'h00, 3'h1, 3'h0}, 32'h100, 2'h0, 3'h0);
		bus(1, cwld_reg_ctrl, 32'h2);
		ld({cwld_op_imm, 5'h00, 3'h1, 3'h0}, 32'h101, 2'h0, 3'h0);
		bus(1, cwld_reg_mask, 32'h1);
		bus(1, cwld_reg_ctrl, 32'h3);
		ld({cwld_op_imm, 5'h01, 3'h1, 3'h7}, 32'h105, cwld_fault_align, 3'h7);
		chk("irq", 32'h1, {31'h0, irq});
		bus(0, cwld_reg_fault, 32'h0);
		chk("fault", {30'h0, cwld_fault_align}, q);
		bus(0, cwld_reg_status, 32'h0);
		chk("abort bit", 32'h1, {31'h0, q[cwld_ev_abort]});
		@(posedge clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		bus(1, cwld_reg_ctrl, 32'h0);
		fail <= 1'b1;
		ld({cwld_op_imm, 5'h00, 3'h1, 3'h1}, 32'h100, cwld_fault_bus, 3'h1);
		chk("irq bus abort", 32'h1, {31'h0, irq});
		fail <= 1'b0;
		bus(1, cwld_reg_mask, 32'h0);
		@(posedge clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		bus(1, cwld_reg_ctrl, 32'h4);
		ld({cwld_op_imm, 5'h00, 3'h1, 3'h3}, 32'h101, cwld_fault_align, 3'h3);
		bus(0, 4'h1, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("Alignment and abort done");
		ld({cwld_op_ldm, 3'h2, 8'h0f}, cwld_wide_ldm_base | 32'h0002000f, 2'h0, 3'h0);
		ld({cwld_op_ldm, 3'h2, 8'hf0}, cwld_wide_ldm_base | 32'h002200f0, 2'h0, 3'h0);
		$display("Wide form done");
		stop_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule : tb_compact_word_load_decode
`default_nettype wire
